//--- design/scmc_pkg.sv
// Purpose: constants, types and state layout of the system clock mode controller
// Assumes: 8-bit registers on a 32-bit classic Wishbone slave, one word each
// Notes:   byte address is four times the register index
package scmc_pkg;

  localparam logic [7:0]  SCMC_IDX_TGC  = 8'h36;
  localparam logic [7:0]  SCMC_IDX_SC1  = 8'h38;
  localparam logic [7:0]  SCMC_IDX_SC2  = 8'h39;
  localparam logic [7:0]  SCMC_IDX_STAT = 8'h3A;
  localparam logic [7:0]  SCMC_ADR_TGC  = {SCMC_IDX_TGC[5:0], 2'b00};
  localparam logic [7:0]  SCMC_ADR_SC1  = {SCMC_IDX_SC1[5:0], 2'b00};
  localparam logic [7:0]  SCMC_ADR_SC2  = {SCMC_IDX_SC2[5:0], 2'b00};
  localparam logic [7:0]  SCMC_ADR_STAT = {SCMC_IDX_STAT[5:0], 2'b00};

  localparam logic [7:0]  SCMC_TGC_RST  = 8'h00;
  localparam int          SCMC_TGC_DV7  = 4;
  localparam int          SCMC_TGC_TBEN = 3;
  localparam int          SCMC_SC1_STOP = 7;
  localparam int          SCMC_SC1_STOP_RELEASE_METHOD = 6;
  localparam int          SCMC_SC1_STOP_RETURN_MODE = 5;
  localparam int          SCMC_SC1_OUTE = 4;
  localparam int          SCMC_SC1_WUT  = 2;
  localparam int          SCMC_SC2_XEN  = 7;
  localparam int          SCMC_SC2_LOW_FREQ_OSC_ENABLE = 6;
  localparam int          SCMC_SC2_SCK  = 5;
  localparam int          SCMC_SC2_IDLE = 4;
  localparam int          SCMC_SC2_HALT = 2;

  // warm-up lengths in basic clocks, codes 00..11
  localparam logic [17:0] SCMC_WARM_FC0 = 18'h30000;
  localparam logic [17:0] SCMC_WARM_FC1 = 18'h10000;
  localparam logic [17:0] SCMC_WARM_FC2 = 18'h0C000;
  localparam logic [17:0] SCMC_WARM_FC3 = 18'h04000;
  localparam logic [17:0] SCMC_WARM_FS0 = 18'h06000;
  localparam logic [17:0] SCMC_WARM_FS1 = 18'h02000;
  localparam logic [17:0] SCMC_WARM_FS2 = 18'h000C0;
  localparam logic [17:0] SCMC_WARM_FS3 = 18'h00040;

  typedef enum logic [3:0] {
    SCMC_NORMAL1, SCMC_NORMAL2, SCMC_SLOW1, SCMC_SLOW2, SCMC_IDLE0, SCMC_IDLE1,
    SCMC_IDLE2, SCMC_SLEEP0, SCMC_SLEEP1, SCMC_SLEEP2, SCMC_STOP, SCMC_WARM
  } scmc_mode_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } scmc_wb_req_s;

  typedef struct packed {
    scmc_mode_e  mode;
    logic [1:0]  pre;
    logic [5:0]  dlo;
    logic [14:0] dhi;
    logic [1:0]  mst;
    logic [7:0]  tgc;
    logic        stop_release_method;
    logic        stop_return_mode;
    logic        outen;
    logic [1:0]  warmup_time_select;
    logic        high_freq_osc_enable;
    logic        low_freq_osc_enable;
    logic        main_clock_select;
    logic [17:0] warm;
    logic        from_n;
    logic        ret_slow;
    logic        tb_arm;
    logic        tb_prev;
    logic [2:0]  lf_s;
    logic        lf_lvl;
    logic [2:0]  sp_s;
    logic        sp_lvl;
    logic        ack;
    logic [7:0]  dat;
    logic        cpu_en;
    logic        per_en;
    logic        tbt_en;
    logic        mcyc;
    logic        irq_take;
    logic        resume;
    logic        tb_latch;
    logic        hf_on;
    logic        lf_on;
    logic        lf_port;
  } scmc_st_s;

  localparam scmc_st_s SCMC_ST_RST = '{mode: SCMC_NORMAL1, high_freq_osc_enable: 1'b1, hf_on: 1'b1, lf_port: 1'b1,
                                       tgc: SCMC_TGC_RST, default: '0};

endpackage : scmc_pkg

//--- design/scmc_top.sv
// Purpose: timing generator, machine cycle sequencer and operating mode control
// Assumes: high-frequency basic clock is mclk_i itself; low-frequency clock arrives on a pin
// Notes:   clocks leave as one-cycle enables; stop release pin is active high
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module scmc_top #(
  parameter logic [17:0] WARM_FC0 = scmc_pkg::SCMC_WARM_FC0,
  parameter logic [17:0] WARM_FC1 = scmc_pkg::SCMC_WARM_FC1,
  parameter logic [17:0] WARM_FC2 = scmc_pkg::SCMC_WARM_FC2,
  parameter logic [17:0] WARM_FC3 = scmc_pkg::SCMC_WARM_FC3,
  parameter logic [17:0] WARM_FS0 = scmc_pkg::SCMC_WARM_FS0,
  parameter logic [17:0] WARM_FS1 = scmc_pkg::SCMC_WARM_FS1,
  parameter logic [17:0] WARM_FS2 = scmc_pkg::SCMC_WARM_FS2,
  parameter logic [17:0] WARM_FS3 = scmc_pkg::SCMC_WARM_FS3
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire scmc_pkg::scmc_wb_req_s wb_req_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   low_freq_osc_in_i,
  input  wire logic                   stop_release_i,
  input  wire logic                   irq_req_i,
  input  wire logic                   interrupt_master_enable_i,
  input  wire logic                   time_base_irq_enable_i,
  output logic                        cpu_clk_en_o,
  output logic                        periph_clk_en_o,
  output logic                        time_base_clk_en_o,
  output logic                        machine_cycle_o,
  output logic [1:0]                  machine_state_o,
  output logic [20:0]                 divider_o,
  output logic                        irq_service_o,
  output logic                        resume_next_o,
  output logic                        time_base_interrupt_latch_o,
  output logic                        high_freq_osc_on_o,
  output logic                        low_freq_osc_on_o,
  output logic                        low_freq_pins_port_o,
  output logic                        port_output_keep_o
);
  import scmc_pkg::*;

  scmc_st_s    r;
  scmc_st_s    next_r;
  logic        fs_tick;
  logic        sp_rise;
  logic        slow;
  logic        fc_run;
  logic        lo_run;
  logic        pre_c;
  logic        c6;
  logic        src7;
  logic        main_tick;
  logic        runs;
  logic        bnd;
  logic        tb_bit;
  logic        tb_fall;
  logic        acc;
  logic        wr;
  logic        stop_req;
  logic        halt_req;
  logic        idle_req;
  logic        warm_tick;
  logic        release_ev;
  logic [7:0]  rd;

  function automatic logic is_slow(input scmc_mode_e m);
    is_slow = (m == SCMC_SLOW1) || (m == SCMC_SLOW2) || (m == SCMC_SLEEP0) ||
              (m == SCMC_SLEEP1) || (m == SCMC_SLEEP2);
  endfunction : is_slow

  function automatic logic is_run(input scmc_mode_e m);
    is_run = (m == SCMC_NORMAL1) || (m == SCMC_NORMAL2) || (m == SCMC_SLOW1) || (m == SCMC_SLOW2);
  endfunction : is_run

  // time-base source taps on prescaler and divider chain
  function automatic logic tb_src(input logic [2:0] code, input logic [22:0] chain);
    case (code)
      3'h0:    tb_src = chain[22];
      3'h1:    tb_src = chain[20];
      3'h2:    tb_src = chain[17];
      3'h3:    tb_src = chain[15];
      3'h4:    tb_src = chain[14];
      3'h5:    tb_src = chain[13];
      3'h6:    tb_src = chain[12];
      default: tb_src = chain[10];
    endcase
  endfunction : tb_src

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    rd     = 8'h00;
    // three-stage synchronisers, level accepted when stages two and three agree
    next_r.lf_s = {r.lf_s[1:0], low_freq_osc_in_i};
    next_r.sp_s = {r.sp_s[1:0], stop_release_i};
    if (r.lf_s[1] == r.lf_s[2]) begin
      next_r.lf_lvl = r.lf_s[2];
    end
    if (r.sp_s[1] == r.sp_s[2]) begin
      next_r.sp_lvl = r.sp_s[2];
    end
    fs_tick = (r.lf_s[1] == r.lf_s[2]) & r.lf_s[2] & ~r.lf_lvl;
    sp_rise = (r.sp_s[1] == r.sp_s[2]) & r.sp_s[2] & ~r.sp_lvl;

    slow   = is_slow(r.mode);
    runs   = (r.mode != SCMC_STOP) && (r.mode != SCMC_WARM);
    fc_run = !((r.mode == SCMC_STOP) || (r.mode == SCMC_SLOW1) || (r.mode == SCMC_SLEEP1) ||
               (r.mode == SCMC_SLEEP0) || ((r.mode == SCMC_WARM) && r.ret_slow));

    // divider chain
    lo_run = fc_run & ~slow;
    pre_c  = lo_run & (r.pre == 2'h3);
    c6     = pre_c & (r.dlo == 6'h3F);
    if (lo_run) begin
      next_r.pre = r.pre + 2'h1;
    end
    if (pre_c) begin
      next_r.dlo = r.dlo + 6'h01;
    end
    if (slow || ((r.mode == SCMC_WARM) && !r.from_n)) begin
      src7 = fs_tick;
    end else if (r.mode == SCMC_WARM) begin
      src7 = c6;
    end else if (r.tgc[SCMC_TGC_DV7]) begin
      src7 = fs_tick;
    end else begin
      src7 = c6;
    end
    if (src7 && (r.mode != SCMC_STOP)) begin
      next_r.dhi = r.dhi + 15'h0001;
    end
    tb_bit         = tb_src(r.tgc[2:0], {r.dhi, r.dlo, r.pre});
    next_r.tb_prev = tb_bit;
    tb_fall        = r.tb_prev & ~tb_bit;

    // main system clock: one state per fc or fs clock
    main_tick = runs & (slow ? fs_tick : fc_run);
    bnd       = main_tick & (r.mst == 2'h3);
    if (main_tick && (r.mode != SCMC_IDLE0) && (r.mode != SCMC_SLEEP0)) begin
      next_r.mst = r.mst + 2'h1;
    end
    next_r.cpu_en   = main_tick & is_run(r.mode);
    next_r.per_en   = main_tick & (r.mode != SCMC_IDLE0) & (r.mode != SCMC_SLEEP0);
    next_r.tbt_en   = main_tick;
    next_r.mcyc     = next_r.per_en & (r.mst == 2'h3);
    next_r.hf_on    = fc_run;
    next_r.lf_on    = r.low_freq_osc_enable & (r.mode != SCMC_STOP);
    next_r.lf_port  = ~r.low_freq_osc_enable;
    next_r.irq_take = 1'b0;
    next_r.resume   = 1'b0;
    next_r.tb_latch = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // classic Wishbone: ack one cycle after strobe, writes land at the ack edge
    acc       = wb_req_i.cyc & wb_req_i.stb;
    wr        = acc & wb_req_i.we & r.ack & wb_req_i.sel[0];
    next_r.ack = acc & ~r.ack;
    case (wb_req_i.adr)
      SCMC_ADR_TGC:  rd = r.tgc;
      SCMC_ADR_SC1:  rd = {1'b0, r.stop_release_method, r.stop_return_mode, r.outen, r.warmup_time_select, 2'b00};
      SCMC_ADR_SC2:  rd = {r.high_freq_osc_enable, r.low_freq_osc_enable, slow, 5'h00};               // clock monitor
      SCMC_ADR_STAT: rd = {r.mst, 2'b00, r.mode};
      default:       rd = 8'h00;
    endcase
    if (acc && !r.ack) begin
      next_r.dat = rd;
    end
    stop_req = 1'b0;
    halt_req = 1'b0;
    idle_req = 1'b0;
    if (wr && (wb_req_i.adr == SCMC_ADR_TGC)) begin
      next_r.tgc = wb_req_i.dat[7:0];
    end
    if (wr && (wb_req_i.adr == SCMC_ADR_SC1)) begin
      next_r.stop_release_method  = wb_req_i.dat[SCMC_SC1_STOP_RELEASE_METHOD];
      next_r.stop_return_mode  = wb_req_i.dat[SCMC_SC1_STOP_RETURN_MODE];
      next_r.outen = wb_req_i.dat[SCMC_SC1_OUTE];
      next_r.warmup_time_select   = wb_req_i.dat[SCMC_SC1_WUT +: 2];
      stop_req     = wb_req_i.dat[SCMC_SC1_STOP];
    end
    if (wr && (wb_req_i.adr == SCMC_ADR_SC2)) begin
      next_r.high_freq_osc_enable   = wb_req_i.dat[SCMC_SC2_XEN];
      next_r.low_freq_osc_enable  = wb_req_i.dat[SCMC_SC2_LOW_FREQ_OSC_ENABLE];
      next_r.main_clock_select = wb_req_i.dat[SCMC_SC2_SCK];
      idle_req     = wb_req_i.dat[SCMC_SC2_IDLE];
      halt_req     = wb_req_i.dat[SCMC_SC2_HALT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    release_ev = r.stop_release_method ? r.sp_lvl : sp_rise;
    warm_tick  = r.ret_slow ? fs_tick : 1'b1;
    case (r.mode)
      SCMC_NORMAL1: begin
        if (r.low_freq_osc_enable) begin
          next_r.mode = SCMC_NORMAL2;
        end
      end
      SCMC_NORMAL2: begin
        if (!r.low_freq_osc_enable) begin
          next_r.mode = SCMC_NORMAL1;
        end else if (r.main_clock_select && bnd) begin
          next_r.mode = SCMC_SLOW2;
        end
      end
      SCMC_SLOW2: begin
        if (!r.high_freq_osc_enable) begin
          next_r.mode = SCMC_SLOW1;
        end else if (!r.main_clock_select && bnd) begin
          next_r.mode = SCMC_NORMAL2;
        end
      end
      SCMC_SLOW1: begin
        if (r.high_freq_osc_enable) begin
          next_r.mode = SCMC_SLOW2;
        end
      end
      SCMC_IDLE1, SCMC_IDLE2, SCMC_SLEEP1, SCMC_SLEEP2: begin
        if (irq_req_i) begin
          case (r.mode)
            SCMC_IDLE1:  next_r.mode = SCMC_NORMAL1;
            SCMC_IDLE2:  next_r.mode = SCMC_NORMAL2;
            SCMC_SLEEP1: next_r.mode = SCMC_SLOW1;
            default:     next_r.mode = SCMC_SLOW2;
          endcase
          next_r.irq_take = interrupt_master_enable_i;
          next_r.resume   = ~interrupt_master_enable_i;
        end
      end
      SCMC_IDLE0, SCMC_SLEEP0: begin
        if (tb_fall) begin
          next_r.mode     = (r.mode == SCMC_IDLE0) ? SCMC_NORMAL1 : SCMC_SLOW1;
          next_r.tb_latch = r.tb_arm;
          next_r.irq_take = interrupt_master_enable_i & time_base_irq_enable_i & r.tb_arm;
          next_r.resume   = ~(interrupt_master_enable_i & time_base_irq_enable_i & r.tb_arm);
        end
      end
      SCMC_STOP: begin
        if (release_ev) begin
          next_r.mode     = SCMC_WARM;
          next_r.ret_slow = r.stop_return_mode;
          next_r.pre      = 2'h0;
          next_r.dlo      = 6'h00;
          next_r.dhi      = 15'h0000;
          case (r.warmup_time_select)
            2'h0:    next_r.warm = r.stop_return_mode ? WARM_FS0 : WARM_FC0;
            2'h1:    next_r.warm = r.stop_return_mode ? WARM_FS1 : WARM_FC1;
            2'h2:    next_r.warm = r.stop_return_mode ? WARM_FS2 : WARM_FC2;
            default: next_r.warm = r.stop_return_mode ? WARM_FS3 : WARM_FC3;
          endcase
        end
      end
      SCMC_WARM: begin
        if (warm_tick) begin
          next_r.warm = r.warm - 18'h00001;
          if (r.warm == 18'h00001) begin
            next_r.mst    = 2'h0;
            next_r.resume = 1'b1;
            if (r.ret_slow) begin
              next_r.mode = SCMC_SLOW1;
            end else begin
              next_r.mode = r.low_freq_osc_enable ? SCMC_NORMAL2 : SCMC_NORMAL1;
            end
          end
        end
      end
      default: next_r.mode = SCMC_NORMAL1;
    endcase

    // software requests taken only from a running mode
    if (is_run(r.mode)) begin
      if (stop_req) begin
        next_r.mode   = SCMC_STOP;
        next_r.from_n = ~slow;
        next_r.pre    = 2'h0;
        next_r.dlo    = 6'h00;
        next_r.dhi    = 15'h0000;
        next_r.mst    = 2'h0;
      end else if (halt_req) begin
        next_r.mode   = slow ? SCMC_SLEEP0 : SCMC_IDLE0;
        next_r.tb_arm = r.tgc[SCMC_TGC_TBEN];
      end else if (idle_req) begin
        case (r.mode)
          SCMC_NORMAL1: next_r.mode = SCMC_IDLE1;
          SCMC_NORMAL2: next_r.mode = SCMC_IDLE2;
          SCMC_SLOW1:   next_r.mode = SCMC_SLEEP1;
          default:      next_r.mode = SCMC_SLEEP2;
        endcase
      end
    end
  end

  // reset is also the pin release of stop: always back to NORMAL1
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= SCMC_ST_RST;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o                    = {24'h000000, r.dat};
  assign wb_ack_o                    = r.ack;
  assign cpu_clk_en_o                = r.cpu_en;
  assign periph_clk_en_o             = r.per_en;
  assign time_base_clk_en_o          = r.tbt_en;
  assign machine_cycle_o             = r.mcyc;
  assign machine_state_o             = r.mst;
  assign divider_o                   = {r.dhi, r.dlo};
  assign irq_service_o               = r.irq_take;
  assign resume_next_o               = r.resume;
  assign time_base_interrupt_latch_o = r.tb_latch;
  assign high_freq_osc_on_o          = r.hf_on;
  assign low_freq_osc_on_o           = r.lf_on;
  assign low_freq_pins_port_o        = r.lf_port;
  assign port_output_keep_o          = r.outen;

  ////////////////////////////////////////////////////////////////////////////////
  property p_stop_clear;
    @(posedge mclk_i) disable iff (rst_i) (r.mode == SCMC_STOP) |-> (r.pre == 2'h0) && ({r.dhi, r.dlo} == 21'h0);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("divider not clear in stop");

  property p_low_frozen;
    @(posedge mclk_i) disable iff (rst_i) slow && $past(slow) |-> $stable(r.dlo) && $stable(r.pre);
  endproperty
  a_low_frozen: assert property (p_low_frozen) else $error("low stages ran in slow");

  property p_slow_fs;
    @(posedge mclk_i) disable iff (rst_i) slow && fs_tick |=> r.dhi == $past(r.dhi) + 15'h0001;
  endproperty
  a_slow_fs: assert property (p_slow_fs) else $error("stage seven missed fs");

  property p_cycle_wrap;
    @(posedge mclk_i) disable iff (rst_i) r.mcyc |-> (r.mst == 2'h0) ##1 ((r.mst == 2'h0) || (r.mst == 2'h1));
  endproperty
  a_cycle_wrap: assert property (p_cycle_wrap) else $error("machine cycle not four states");

  property p_switch_bnd;
    @(posedge mclk_i) disable iff (rst_i) $changed(slow) && $past(runs) && runs |-> $past(r.mst) == 2'h3;
  endproperty
  a_switch_bnd: assert property (p_switch_bnd) else $error("clock switched mid cycle");

  property p_idle1_wake;
    @(posedge mclk_i) disable iff (rst_i) (r.mode == SCMC_IDLE1) && irq_req_i
      |=> (r.mode == SCMC_NORMAL1) && (r.irq_take != r.resume);
  endproperty
  a_idle1_wake: assert property (p_idle1_wake) else $error("idle1 wake wrong");

  property p_ime_take;
    @(posedge mclk_i) disable iff (rst_i) (r.mode == SCMC_IDLE2) && irq_req_i && interrupt_master_enable_i
      |=> r.irq_take ##1 !r.irq_take;
  endproperty
  a_ime_take: assert property (p_ime_take) else $error("interrupt not serviced on wake");

  property p_idle0_latch;
    @(posedge mclk_i) disable iff (rst_i) (r.mode == SCMC_IDLE0) && tb_fall && r.tb_arm
      |=> r.tb_latch && (r.mode == SCMC_NORMAL1);
  endproperty
  a_idle0_latch: assert property (p_idle0_latch) else $error("idle0 latch missing");

  property p_sleep0_ret;
    @(posedge mclk_i) disable iff (rst_i) (r.mode == SCMC_SLEEP0) && tb_fall |=> r.mode == SCMC_SLOW1;
  endproperty
  a_sleep0_ret: assert property (p_sleep0_ret) else $error("sleep0 not back to slow1");

  property p_warm_slow;
    @(posedge mclk_i) disable iff (rst_i) (r.mode == SCMC_WARM) && r.ret_slow && (r.warm == 18'h00001) && fs_tick
      |=> (r.mode == SCMC_SLOW1) && r.resume;
  endproperty
  a_warm_slow: assert property (p_warm_slow) else $error("stop return mode wrong");

endmodule : scmc_top

//--- tb/scmc_far_model.sv
// Purpose: far-side model, low-frequency oscillator
// Assumes: fs period of 16 mclk
// Notes:   fs stands still low while its oscillator is off
`timescale 1ns/1ps
module scmc_far_model (
  input  wire logic mclk_i,
  input  wire logic osc_on_i,
  output logic      fs_o
);
  logic [2:0] cnt = 3'h0;
  initial fs_o = 1'b0;
  always @(posedge mclk_i) begin
    cnt <= cnt + 3'h1;
    if (!osc_on_i) begin
      fs_o <= 1'b0;
    end else if (cnt == 3'h7) begin
      fs_o <= ~fs_o;
    end
  end
endmodule : scmc_far_model

//--- tb/scmc_tb_top.sv
// Purpose: self-checking bench for the clock mode controller
// Assumes: short WARM_FC3 warm-up parameter, fs from the far-side model
// Notes:   one Wishbone request at a time
`timescale 1ns/1ps
module system_clock_mode_controller_tb_top;
  import scmc_pkg::*;
  logic         mclk_i = 1'b0;
  logic         rst_i = 1'b1;
  scmc_wb_req_s req = '0;
  logic         irq = 1'b0, ime = 1'b0, stp = 1'b0, tbe = 1'b1;
  logic         fs, ack, cpu_en, per_en, svc, res, tbl, hf, lf, port;
  logic [31:0]  wb_dat;
  logic [20:0]  div;
  logic [7:0]   q;
  int           bad_count = 0;
  int           n_checks = 0;
  always #12.5 mclk_i = ~mclk_i;
  // only code 11 from fast clock is used before a reset ends the second stop
  scmc_top #(.WARM_FC3(18'h4)) uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat), .wb_ack_o(ack),
    .low_freq_osc_in_i(fs), .stop_release_i(stp), .irq_req_i(irq), .interrupt_master_enable_i(ime),
    .time_base_irq_enable_i(tbe), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
    .time_base_clk_en_o(), .machine_cycle_o(), .machine_state_o(), .divider_o(div),
    .irq_service_o(svc), .resume_next_o(res), .time_base_interrupt_latch_o(tbl),
    .high_freq_osc_on_o(hf), .low_freq_osc_on_o(lf), .low_freq_pins_port_o(port), .port_output_keep_o());
  scmc_far_model far (.mclk_i(mclk_i), .osc_on_i(lf), .fs_o(fs));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: {24'h0, d}};
    do @(posedge mclk_i); while (ack !== 1'b1 && ++n < 20);
    chk("ack", 1, n < 20);
    q = wb_dat[7:0];
    req <= '0;
  endtask : bus
  task automatic mode_is(input scmc_mode_e m);
    int n;
    n = 0;
    do bus(1'b0, SCMC_ADR_STAT, 8'h00); while (q[3:0] !== m && ++n < 40);
    chk("mode", 32'(m), 32'(q[3:0]));
  endtask : mode_is
  // k: 0 service, 1 resume, 2 time-base latch
  task automatic wait_pulse(input int k, input int lim);
    int n;
    n = 0;
    do @(posedge mclk_i); while (!(k == 0 ? svc === 1'b1 : k == 1 ? res === 1'b1 : tbl === 1'b1) && ++n < lim);
    chk("pulse", 1, n < lim);
  endtask : wait_pulse
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk("hf_on", 1, hf);
    chk("port", 1, port);
    mode_is(SCMC_NORMAL1);
    bus(1'b0, SCMC_ADR_TGC, 8'h00);
    chk("tgc_rst", 8'h00, q);
    bus(1'b1, SCMC_ADR_TGC, 8'hEF);
    bus(1'b0, SCMC_ADR_TGC, 8'h00);
    chk("tgc", 8'hEF, q);
    bus(1'b1, 8'h04, 8'hFF);
    bus(1'b0, 8'h04, 8'h00);
    chk("unmapped", 8'h00, q);
  endtask : t_regs
  task automatic t_idle(input logic v);
    bus(1'b1, SCMC_ADR_SC2, 8'h90);
    mode_is(SCMC_IDLE1);
    chk("cpu_en", 0, cpu_en);
    chk("per_en", 1, per_en);
    @(posedge mclk_i);
    ime <= v;
    irq <= 1'b1;
    wait_pulse(v ? 0 : 1, 10);
    irq <= 1'b0;
    mode_is(SCMC_NORMAL1);
  endtask : t_idle
  task automatic t_idle0;
    ime <= 1'b1;
    bus(1'b1, SCMC_ADR_TGC, 8'h0F);
    bus(1'b1, SCMC_ADR_SC2, 8'h84);
    mode_is(SCMC_IDLE0);
    chk("per_off", 0, per_en);
    wait_pulse(2, 3000);
    chk("svc", 1, svc);
    mode_is(SCMC_NORMAL1);
  endtask : t_idle0
  task automatic t_stop;
    bus(1'b1, SCMC_ADR_SC1, 8'hCC);
    mode_is(SCMC_STOP);
    chk("div_clr", 0, div);
    chk("hf_off", 0, hf);
    @(posedge mclk_i);
    stp <= 1'b1;
    wait_pulse(1, 100);
    stp <= 1'b0;
    mode_is(SCMC_NORMAL1);
    bus(1'b1, SCMC_ADR_SC1, 8'hC0);
    mode_is(SCMC_STOP);
    rst_i <= 1'b1;
    @(posedge mclk_i);
    rst_i <= 1'b0;
    mode_is(SCMC_NORMAL1);
  endtask : t_stop
  task automatic t_dual;
    logic [5:0] d;
    bus(1'b1, SCMC_ADR_SC2, 8'hC0);
    mode_is(SCMC_NORMAL2);
    chk("port2", 0, port);
    bus(1'b1, SCMC_ADR_SC2, 8'hE0);
    mode_is(SCMC_SLOW2);
    bus(1'b1, SCMC_ADR_SC2, 8'h60);
    mode_is(SCMC_SLOW1);
    chk("hf_slow1", 0, hf);
    d = div[5:0];
    repeat (40) @(posedge mclk_i);
    chk("div_low", d, div[5:0]);
    bus(1'b1, SCMC_ADR_SC2, 8'hE0);
    mode_is(SCMC_SLOW2);
    bus(1'b1, SCMC_ADR_SC2, 8'hC0);
    mode_is(SCMC_NORMAL2);
  endtask : t_dual
  task automatic finish_test;
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs;
    t_idle(1'b1);
    t_idle(1'b0);
    t_idle0;
    t_stop;
    t_dual;
    finish_test;
  end
endmodule : system_clock_mode_controller_tb_top
